/* hw/sscte_regs.vh */
/*
 * register indices, select codes and reset values of the scan clock
 * and trigger block. assumes a 25 MHz device clock.
 */
`ifndef SSCTE_REGS_VH
`define SSCTE_REGS_VH
// =============================================
// register indices (word address = 4 * index)
`define SSCTE_IDX_CLOCK_SELECT 16'h0FAE
`define SSCTE_IDX_NUM_SCANS 16'h0FB4
`define SSCTE_IDX_PULSE_DIVISOR 16'h0FB6
`define SSCTE_IDX_TRIGGER_SELECT 16'h0FB8
`define SSCTE_IDX_START_STAMP 16'h0FBA
`define SSCTE_IDX_RUN_CONTROL 16'h0FBC
`define SSCTE_IDX_SCAN_PERIOD 16'h0FC0
`define SSCTE_IDX_EDGE_POLARITY 16'h0FC2
`define SSCTE_IDX_STATUS 16'h0FC4
`define SSCTE_IDX_OUT_CTRL 16'h0FC6
`define SSCTE_IDX_OUT_LEN 16'h0FC8
// =============================================
// select codes
`define SSCTE_CLK_INTERNAL 32'h00000000
`define SSCTE_CLK_EXTERNAL 32'h00000002
`define SSCTE_TRIG_NONE 32'h00000000
`define SSCTE_TRIG_BASE 32'h000007D0
// =============================================
// reset values
`define SSCTE_RST_DIVISOR 32'h00000001
`define SSCTE_RST_PERIOD 32'h000061A8
`endif

/* hw/sscte_out_chan.v */
/*
 * one waveform output channel: keeps a read position into its buffer
 * and advances it once per scan, linear or looping.
 * assumes the buffer memory lives with the caller.
 */
`timescale 1ns/10ps
module sscte_out_chan
#(
    parameter AW = 8
)
(
    input wire clk_i,
    input wire resetn_i,
    input wire chan_reset_i,
    input wire enable_i,
    input wire loop_i,
    input wire [AW-1:0] len_i,
    input wire scan_i,
    output reg [AW-1:0] pos_o,
    output reg valid_o
);
    // =============================================
    // position counter
    // position survives stop and restart, only chan_reset or resetn clears it
    always @(posedge clk_i)
    begin
        if (!resetn_i || chan_reset_i)
        begin
            pos_o <= {AW{1'b0}};
            valid_o <= 1'b0;
        end
        else if (scan_i && enable_i)
        begin
            valid_o <= 1'b1;
            if (pos_o + 1'b1 >= len_i)
            begin
                if (loop_i)
                    pos_o <= {AW{1'b0}};
            end
            else
                pos_o <= pos_o + 1'b1;
        end
        else
            valid_o <= 1'b0;
    end
endmodule // sscte_out_chan

/* hw/sscte_top.v */
/*
 * scan tick generation, start trigger and waveform output channels of
 * a streaming acquisition engine, with a simple word register port.
 * assumes pin event pulses and the external clock pin are asynchronous.
 */
`timescale 1ns/10ps
`include "sscte_regs.vh"
module sscte_top
#(
    parameter NCH = 4,
    parameter AW = 8,
    parameter NEF = 8
)
(
    input wire clk_i,
    input wire resetn_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [15:0] reg_idx_i,
    input wire [31:0] reg_wdata_i,
    output reg [31:0] reg_rdata_o,
    input wire ext_scan_clock_pin_i,
    input wire [NEF-1:0] pin_event_function_i,
    input wire [NEF-1:0] pin_event_pw_mode_i,
    input wire [31:0] core_timer_i,
    output reg scan_tick_o,
    output reg running_o,
    output reg [NCH*16-1:0] out_data_o,
    output reg [NCH-1:0] out_valid_o
);
    // =============================================
    // state
    localparam ST_IDLE = 2'b00;
    localparam ST_WAIT_TRIG = 2'b01;
    localparam ST_FIRST = 2'b10;
    localparam ST_RUN = 2'b11;

    reg [31:0] clk_sel_q;
    reg [31:0] divisor_q;
    reg [31:0] trig_sel_q;
    reg [31:0] num_scans_q;
    reg [31:0] period_q;
    reg [NEF-1:0] edge_fall_q;
    reg [31:0] stamp_q;
    reg [31:0] scan_cnt_q;
    reg [31:0] tick_cnt_q;
    reg [31:0] edge_cnt_q;
    reg [1:0] state_q;
    reg run_q;
    reg [NCH-1:0] out_en_q;
    reg [NCH-1:0] out_loop_q;
    reg [NCH-1:0] out_rst_q;
    reg [NCH*AW-1:0] out_len_q;
    reg [2:0] ext_sync_q;
    reg [3*NEF-1:0] ef_sync_q;
    reg [15:0] buf_q [0:NCH*(1<<AW)-1];
    wire [NCH*AW-1:0] pos_w;
    wire [NCH-1:0] valid_w;

    // =============================================
    // input synchronisers
    // a change counts once the second and third stages differ
    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            ext_sync_q <= 3'h0;
            ef_sync_q <= {3*NEF{1'b0}};
        end
        else
        begin
            ext_sync_q <= {ext_sync_q[1:0], ext_scan_clock_pin_i};
            ef_sync_q <= {ef_sync_q[2*NEF-1:0], pin_event_function_i};
        end
    end

    wire ext_rise = ext_sync_q[1] & ~ext_sync_q[2];
    wire [NEF-1:0] ef_rise = ef_sync_q[2*NEF-1:NEF] & ~ef_sync_q[3*NEF-1:2*NEF];
    wire [NEF-1:0] ef_fall = ~ef_sync_q[2*NEF-1:NEF] & ef_sync_q[3*NEF-1:2*NEF];

    // =============================================
    // trigger decode
    reg [NEF-1:0] ef_hit;
    genvar g;
    generate
        for (g = 0; g < NEF; g = g + 1)
        begin : g_ef
            always @*
            begin
                if (pin_event_pw_mode_i[g])
                    ef_hit[g] = ef_rise[g] | ef_fall[g];
                else if (edge_fall_q[g])
                    ef_hit[g] = ef_fall[g];
                else
                    ef_hit[g] = ef_rise[g];
            end
        end
    endgenerate

    wire [31:0] trig_off = trig_sel_q - `SSCTE_TRIG_BASE;
    wire trig_ok = (trig_sel_q >= `SSCTE_TRIG_BASE) &&
        (trig_off < 32'h00000008) && (trig_off[2:1] != 2'b10);
    wire trig_hit = trig_ok && ef_hit[trig_off[2:0]];

    // =============================================
    // scan period generation
    wire ext_mode = (clk_sel_q == `SSCTE_CLK_EXTERNAL);
    wire timing = (state_q == ST_FIRST) || (state_q == ST_RUN);
    wire period_done = ext_mode ?
        (ext_rise && (edge_cnt_q + 32'h00000001 >= divisor_q)) :
        (tick_cnt_q + 32'h00000001 >= period_q);
    wire scan_w = timing && period_done;
    wire last_scan = (num_scans_q != 32'h00000000) &&
        (scan_cnt_q + 32'h00000001 >= num_scans_q);

    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            state_q <= ST_IDLE;
            tick_cnt_q <= 32'h00000000;
            edge_cnt_q <= 32'h00000000;
            scan_cnt_q <= 32'h00000000;
            stamp_q <= 32'h00000000;
            scan_tick_o <= 1'b0;
            running_o <= 1'b0;
        end
        else
        begin
            scan_tick_o <= scan_w;
            running_o <= timing;
            if (!timing || scan_w)
            begin
                tick_cnt_q <= 32'h00000000;
                edge_cnt_q <= 32'h00000000;
            end
            else
            begin
                tick_cnt_q <= tick_cnt_q + 32'h00000001;
                if (ext_rise)
                    edge_cnt_q <= edge_cnt_q + 32'h00000001;
            end
            case (state_q)
                ST_IDLE:
                    if (run_q)
                    begin
                        scan_cnt_q <= 32'h00000000;
                        if (trig_sel_q == `SSCTE_TRIG_NONE)
                            state_q <= ST_FIRST;
                        else
                            state_q <= ST_WAIT_TRIG;
                    end
                ST_WAIT_TRIG:
                    if (!run_q)
                        state_q <= ST_IDLE;
                    else if (trig_hit)
                        state_q <= ST_FIRST;
                ST_FIRST:
                    if (!run_q)
                        state_q <= ST_IDLE;
                    else if (scan_w)
                    begin
                        stamp_q <= core_timer_i;
                        scan_cnt_q <= 32'h00000001;
                        state_q <= last_scan ? ST_IDLE : ST_RUN;
                    end
                ST_RUN:
                    if (!run_q)
                        state_q <= ST_IDLE;
                    else if (scan_w)
                    begin
                        scan_cnt_q <= scan_cnt_q + 32'h00000001;
                        if (last_scan)
                            state_q <= ST_IDLE;
                    end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // =============================================
    // register port
    // run control drops by itself when a burst ends
    wire burst_end = timing && scan_w && last_scan;
    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            clk_sel_q <= `SSCTE_CLK_INTERNAL;
            divisor_q <= `SSCTE_RST_DIVISOR;
            trig_sel_q <= `SSCTE_TRIG_NONE;
            num_scans_q <= 32'h00000000;
            period_q <= `SSCTE_RST_PERIOD;
            edge_fall_q <= {NEF{1'b0}};
            run_q <= 1'b0;
            out_en_q <= {NCH{1'b0}};
            out_loop_q <= {NCH{1'b0}};
            out_rst_q <= {NCH{1'b0}};
            out_len_q <= {NCH*AW{1'b0}};
        end
        else
        begin
            out_rst_q <= {NCH{1'b0}};
            if (burst_end)
                run_q <= 1'b0;
            if (reg_wr_i)
            begin
                case (reg_idx_i)
                    `SSCTE_IDX_CLOCK_SELECT: clk_sel_q <= reg_wdata_i;
                    `SSCTE_IDX_PULSE_DIVISOR: divisor_q <= reg_wdata_i;
                    `SSCTE_IDX_TRIGGER_SELECT: trig_sel_q <= reg_wdata_i;
                    `SSCTE_IDX_NUM_SCANS: num_scans_q <= reg_wdata_i;
                    `SSCTE_IDX_SCAN_PERIOD: period_q <= reg_wdata_i;
                    `SSCTE_IDX_EDGE_POLARITY:
                        edge_fall_q <= reg_wdata_i[NEF-1:0];
                    `SSCTE_IDX_RUN_CONTROL:
                        if (!burst_end)
                            run_q <= reg_wdata_i[0];
                    `SSCTE_IDX_OUT_CTRL:
                    begin
                        out_en_q <= reg_wdata_i[NCH-1:0];
                        out_loop_q <= reg_wdata_i[NCH+7:8];
                        out_rst_q <= reg_wdata_i[NCH+15:16];
                    end
                    `SSCTE_IDX_OUT_LEN:
                        out_len_q <= reg_wdata_i[NCH*AW-1:0];
                    default: ;
                endcase
            end
        end
    end

    // buffer load: bits 31:30 channel, AW-1+16:16 address, 15:0 data
    always @(posedge clk_i)
    begin
        if (reg_wr_i && reg_idx_i[15:8] == 8'h11)
            buf_q[{reg_wdata_i[31:30], reg_wdata_i[AW+15:16]}] <=
                reg_wdata_i[15:0];
    end

    always @(posedge clk_i)
    begin
        if (!resetn_i)
            reg_rdata_o <= 32'h00000000;
        else if (reg_rd_i)
        begin
            case (reg_idx_i)
                `SSCTE_IDX_CLOCK_SELECT: reg_rdata_o <= clk_sel_q;
                `SSCTE_IDX_PULSE_DIVISOR: reg_rdata_o <= divisor_q;
                `SSCTE_IDX_TRIGGER_SELECT: reg_rdata_o <= trig_sel_q;
                `SSCTE_IDX_NUM_SCANS: reg_rdata_o <= num_scans_q;
                `SSCTE_IDX_SCAN_PERIOD: reg_rdata_o <= period_q;
                `SSCTE_IDX_START_STAMP: reg_rdata_o <= stamp_q;
                `SSCTE_IDX_RUN_CONTROL: reg_rdata_o <= {31'h0, run_q};
                `SSCTE_IDX_STATUS: reg_rdata_o <= {30'h0, state_q};
                default: reg_rdata_o <= 32'h00000000;
            endcase
        end
    end

    // =============================================
    // output channels
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : g_ch
            sscte_out_chan #(.AW(AW)) u_ch
            (
                .clk_i(clk_i),
                .resetn_i(resetn_i),
                .chan_reset_i(out_rst_q[g]),
                .enable_i(out_en_q[g]),
                .loop_i(out_loop_q[g]),
                .len_i(out_len_q[g*AW +: AW]),
                .scan_i(scan_w),
                .pos_o(pos_w[g*AW +: AW]),
                .valid_o(valid_w[g])
            );
            always @(posedge clk_i)
            begin
                if (!resetn_i)
                begin
                    out_data_o[g*16 +: 16] <= 16'h0000;
                    out_valid_o[g] <= 1'b0;
                end
                else
                begin
                    out_valid_o[g] <= valid_w[g];
                    if (scan_w && out_en_q[g])
                        out_data_o[g*16 +: 16] <=
                            buf_q[g*(1<<AW) + pos_w[g*AW +: AW]];
                end
            end
        end
    endgenerate
endmodule // sscte_top

/* tb/sscte_pulse_src.sv */
/* external pulse source: scan clock pin pulses and event levels.
   assumes the caller runs its tasks from one process at a time. */
`timescale 1ns/10ps
module sscte_pulse_src
#(
    parameter NEF = 8
)
(
    input wire logic clk_i,
    output logic ext_o,
    output logic [NEF-1:0] ev_o
);
// ====
// idle levels: pin low, no events
initial
begin
    ext_o = 1'b0;
    ev_o = '0;
end
// ====
// slow pulses, so the synchroniser sees every edge
task automatic pulses(input int n);
    repeat (n)
    begin
        @(posedge clk_i);
        ext_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        ext_o <= 1'b0;
        repeat (3) @(posedge clk_i);
    end
endtask
task automatic ev(input int k, input logic v);
    @(posedge clk_i);
    ev_o[k] <= v;
    repeat (4) @(posedge clk_i);
endtask
endmodule // sscte_pulse_src

/* tb/sscte_top_properties.sv */
/* checker of port timing of sscte_top.
   assumes it is bound to sscte_top and sees only its ports. */
`timescale 1ns/10ps
`include "sscte_regs.vh"
module sscte_top_properties
#(
    parameter NCH = 4,
    parameter AW = 8,
    parameter NEF = 8
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_idx_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic ext_scan_clock_pin_i,
    input wire logic [NEF-1:0] pin_event_function_i,
    input wire logic [NEF-1:0] pin_event_pw_mode_i,
    input wire logic [31:0] core_timer_i,
    input wire logic scan_tick_o,
    input wire logic running_o,
    input wire logic [NCH*16-1:0] out_data_o,
    input wire logic [NCH-1:0] out_valid_o
);
// ====
// clocking and sequences
default clocking cb @(posedge clk_i);
endclocking
default disable iff (!resetn_i);
sequence run_wr(bit v);
    reg_wr_i && reg_idx_i == `SSCTE_IDX_RUN_CONTROL && reg_wdata_i[0] == v;
endsequence
// with a trigger armed, running_o waits for the event, so track the select
logic trig_none_q;
always @(posedge clk_i)
begin
    if (!resetn_i)
        trig_none_q <= 1'b1;
    else if (reg_wr_i && reg_idx_i == `SSCTE_IDX_TRIGGER_SELECT)
        trig_none_q <= (reg_wdata_i == `SSCTE_TRIG_NONE);
end
// ====
// assertions
a_tick_pulse: assert property (scan_tick_o |=> !scan_tick_o)
    else $error("scan tick wider than one cycle");
a_tick_running: assert property (scan_tick_o |-> $past(running_o))
    else $error("scan tick while idle");
a_valid_tick: assert property (|out_valid_o |-> $past(scan_tick_o))
    else $error("output valid without a scan");
a_data_scan: assert property ($changed(out_data_o) |->
    scan_tick_o || |out_valid_o)
    else $error("output data moved between scans");
// run_q, then state, then the registered running_o: three edges
a_run_starts: assert property (run_wr(1'b1) ##0 (!running_o && trig_none_q)
    |-> ##3 running_o)
    else $error("run write did not start");
a_run_stops: assert property (run_wr(1'b0) |-> ##3 !running_o)
    else $error("run clear did not stop");
a_rdata_holds: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data moved without a read");
a_reset_clears: assert property (disable iff (1'b0) !resetn_i |=>
    !scan_tick_o && !running_o && out_valid_o == '0 &&
    out_data_o == '0 && reg_rdata_o == '0)
    else $error("outputs not cleared by reset");
endmodule // sscte_top_properties
bind sscte_top sscte_top_properties #(.NCH(NCH), .AW(AW), .NEF(NEF))
    i_sscte_top_properties (.clk_i, .resetn_i, .reg_wr_i, .reg_rd_i,
    .reg_idx_i, .reg_wdata_i, .reg_rdata_o, .ext_scan_clock_pin_i,
    .pin_event_function_i, .pin_event_pw_mode_i, .core_timer_i,
    .scan_tick_o, .running_o, .out_data_o, .out_valid_o);

/* tb/tb.sv */
/* self-checking bench of sscte_top with an external pulse source.
   assumes the header of register indices is on the include path. */
`timescale 1ns/10ps
`include "sscte_regs.vh"
module tb;
localparam [15:0] CSEL = `SSCTE_IDX_CLOCK_SELECT, NSC = `SSCTE_IDX_NUM_SCANS,
    DIV = `SSCTE_IDX_PULSE_DIVISOR, TRG = `SSCTE_IDX_TRIGGER_SELECT,
    RUN = `SSCTE_IDX_RUN_CONTROL, PER = `SSCTE_IDX_SCAN_PERIOD,
    POL = `SSCTE_IDX_EDGE_POLARITY, OCT = `SSCTE_IDX_OUT_CTRL;
logic clk_i, resetn_i, reg_wr_i, reg_rd_i;
logic [15:0] reg_idx_i;
logic [31:0] reg_wdata_i, v;
logic [31:0] core_timer_i = 32'h1234ABCD;
logic [7:0] pw_mode;
wire [31:0] reg_rdata_o;
wire ext_pin, scan_tick_o, running_o;
wire [7:0] ev;
wire [63:0] out_data_o;
wire [3:0] out_valid_o;
int fails = 0, checks = 0, ticks = 0, n, t0;
sscte_top i_sscte_top (.clk_i, .resetn_i, .reg_wr_i, .reg_rd_i,
    .reg_idx_i, .reg_wdata_i, .reg_rdata_o, .ext_scan_clock_pin_i(ext_pin),
    .pin_event_function_i(ev), .pin_event_pw_mode_i(pw_mode),
    .core_timer_i, .scan_tick_o, .running_o, .out_data_o, .out_valid_o);
sscte_pulse_src i_sscte_pulse_src (.clk_i, .ext_o(ext_pin), .ev_o(ev));
initial
begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
end
// timer steps after each tick, so a late stamp capture shows
always @(posedge clk_i)
begin
    if (scan_tick_o)
    begin
        ticks <= ticks + 1;
        core_timer_i <= core_timer_i + 32'h1;
    end
end
// ====
// shared tasks
task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
        fails++;
        $display("wrong value at %0t: %h not %h", $time, s, e);
    end
endtask
task automatic wr(input logic [15:0] i, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_idx_i <= i;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
endtask
task automatic rd(input logic [15:0] i, output logic [31:0] d);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_idx_i <= i;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
endtask
// waits for a scan tick, or for a channel 0 sample when vch is set
task automatic wt(input bit vch, output int c);
    c = 0;
    do
    begin
        @(posedge clk_i);
        #1 c++;
    end
    while ((vch ? out_valid_o[0] : scan_tick_o) !== 1'b1 && c < 200);
    if (c >= 200)
        fails++;
endtask
task automatic final_report;
    if (fails == 0 && checks > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
// ====
// scenarios
task automatic t_regs;
    rd(DIV, v);
    chk(v, `SSCTE_RST_DIVISOR);
    rd(PER, v);
    chk(v, `SSCTE_RST_PERIOD);
    wr(16'h0100, 32'hFFFFFFFF);
    rd(16'h0100, v);
    chk(v, 32'h0);
    wr(CSEL, `SSCTE_CLK_EXTERNAL);
    rd(CSEL, v);
    chk(v, `SSCTE_CLK_EXTERNAL);
    wr(CSEL, `SSCTE_CLK_INTERNAL);
endtask
task automatic t_int;
    wr(PER, 32'h14);
    wr(NSC, 32'h3);
    wr(TRG, `SSCTE_TRIG_NONE);
    wr(RUN, 32'h1);
    wt(0, n);
    chk(n, 21);
    wt(0, n);
    chk(n, 20);
    wt(0, n);
    chk(n, 20);
    repeat (4) @(posedge clk_i);
    chk(running_o, 1'b0);
    rd(`SSCTE_IDX_START_STAMP, v);
    chk(v, 32'h1234ABCD);
    wr(NSC, 32'h0);
    t0 = ticks;
    wr(RUN, 32'h1);
    repeat (100) @(posedge clk_i);
    chk(ticks - t0, 4);
    wr(RUN, 32'h0);
endtask
task automatic t_ext;
    wr(CSEL, `SSCTE_CLK_EXTERNAL);
    wr(DIV, 32'h3);
    t0 = ticks;
    wr(RUN, 32'h1);
    i_sscte_pulse_src.pulses(7);
    repeat (10) @(posedge clk_i);
    chk(ticks - t0, 2);
    wr(RUN, 32'h0);
    wr(CSEL, `SSCTE_CLK_INTERNAL);
endtask
task automatic t_trig;
    wr(PER, 32'hA);
    wr(NSC, 32'h1);
    for (int k = 0; k < 8; k++)
    begin
        wr(TRG, `SSCTE_TRIG_BASE + k);
        t0 = ticks;
        wr(RUN, 32'h1);
        i_sscte_pulse_src.ev(k, 1'b1);
        i_sscte_pulse_src.ev(k, 1'b0);
        chk(ticks - t0, 0);
        repeat (30) @(posedge clk_i);
        chk(ticks - t0, (k == 4 || k == 5) ? 0 : 1);
        wr(RUN, 32'h0);
    end
    wr(POL, 32'h1);
    wr(TRG, `SSCTE_TRIG_BASE);
    t0 = ticks;
    wr(RUN, 32'h1);
    i_sscte_pulse_src.ev(0, 1'b1);
    repeat (30) @(posedge clk_i);
    chk(ticks - t0, 0);
    i_sscte_pulse_src.ev(0, 1'b0);
    repeat (30) @(posedge clk_i);
    chk(ticks - t0, 1);
    pw_mode <= 8'h02;
    wr(POL, 32'h2);
    wr(TRG, `SSCTE_TRIG_BASE + 1);
    t0 = ticks;
    wr(RUN, 32'h1);
    i_sscte_pulse_src.ev(1, 1'b1);
    repeat (30) @(posedge clk_i);
    chk(ticks - t0, 1);
    wr(RUN, 32'h0);
    wr(POL, 32'h0);
endtask
task automatic t_out;
    // length, buffer, then enable and loop, then run
    wr(TRG, `SSCTE_TRIG_NONE);
    wr(`SSCTE_IDX_OUT_LEN, 32'h2);
    wr(16'h1100, 32'h00001111);
    wr(16'h1100, 32'h00012222);
    wr(OCT, 32'h00000101);
    wr(NSC, 32'h3);
    wr(RUN, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
        wt(1, n);
        chk(out_data_o[15:0], i[0] ? 16'h2222 : 16'h1111);
    end
    chk(out_valid_o, 4'h1);
    wr(NSC, 32'h1);
    wr(RUN, 32'h1);
    wt(1, n);
    chk(out_valid_o, 4'h1);
    chk(out_data_o[15:0], 16'h2222);
    wr(OCT, 32'h00010101);
    wr(RUN, 32'h1);
    wt(1, n);
    chk(out_data_o[15:0], 16'h1111);
    wr(OCT, 32'h00000001);
    wr(NSC, 32'h2);
    wr(RUN, 32'h1);
    wt(1, n);
    chk(out_data_o[15:0], 16'h2222);
    // refill the held entry while streaming runs
    wr(16'h1100, 32'h00013333);
    wt(1, n);
    chk(out_data_o[15:0], 16'h3333);
endtask
// ====
// main sequence and watchdog
initial
begin
    resetn_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_idx_i = 16'h0;
    reg_wdata_i = 32'h0;
    pw_mode = 8'h00;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_regs;
    t_int;
    t_ext;
    t_trig;
    t_out;
    final_report;
end
initial
begin
    #(40 * 20000);
    fails++;
    final_report;
end
endmodule // tb
